// ==== common/rcc_defines.svh ====
// Purpose: Constants for the reset cause and start-up delay controller
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes: Register indexes times four give byte addresses; own registers use byte addresses
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH
`define RCC_IDX_STATUS 8'h03
`define RCC_IDX_POWER_CONTROL 8'h8E
`define RCC_OFF_STATUS {`RCC_IDX_STATUS, 2'b00}
`define RCC_OFF_POWER_CONTROL {`RCC_IDX_POWER_CONTROL, 2'b00}
`define RCC_OFF_IRQ_STAT 10'h040
`define RCC_OFF_IRQ_MASK 10'h044
`define RCC_OFF_CTRL 10'h048
`define RCC_OFF_CORE 10'h04C
`define RCC_STATUS_RST 8'h18
`define RCC_POWER_CONTROL_POR_BIT 1
`define RCC_ST_PD_BIT 3
`define RCC_ST_TO_BIT 4
`define RCC_POWERUP_TIMER_MS 72
`define RCC_CLK_MHZ 250
`define RCC_POWERUP_TIMER_CYC (`RCC_POWERUP_TIMER_MS * 1000 * `RCC_CLK_MHZ)
`define RCC_OST_CYC 1024
`define RCC_RESET_VEC 13'h0000
`define RCC_IRQ_VEC 13'h0004
`define RCC_ALL_ONES 8'hFF
`define RCC_ZERO8 8'h00
`endif

// ==== common/rcc_pkg.sv ====
// Purpose: Types for the reset cause controller
// Assumes: Nothing
// Notes: Struct carries all state except the registered pc_load output
package rcc_pkg;
	typedef enum logic [2:0] {
		RCC_IDLE = 3'b000,
		RCC_POWERUP_TIMER = 3'b001,
		RCC_OST = 3'b011,
		RCC_HOLD = 3'b010,
		RCC_RUN = 3'b110
	} rcc_state_e;
	typedef enum logic [1:0] {
		RCC_MODE_LP = 2'b00,
		RCC_MODE_XT = 2'b01,
		RCC_MODE_HS = 2'b10,
		RCC_MODE_RC = 2'b11
	} rcc_osc_e;
	typedef struct packed {
		logic [12:0] pc;
		logic [7:0] status;
		logic por_flag;
		logic [7:0] option;
		logic [7:0] port_a_direction;
		logic [7:0] port_b_direction;
		logic [7:0] irq_control_reg;
		logic [4:0] pc_high_latch;
	} rcc_core_s;
	typedef struct packed {
		rcc_state_e state;
		logic [24:0] cnt;
		logic [10:0] ost_cnt;
		logic pending_vec;
		rcc_core_s core;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [1:0] osc_mode;
		logic powerup_timer_enable_n_n;
		logic aw_hold;
		logic [9:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] master_clear_n_sync;
		logic [1:0] osc_sync;
		logic osc_last;
		logic sleep_q;
	} rcc_state_s;
endpackage : rcc_pkg

// ==== verilog/rcc_top.sv ====
// Purpose: Reset cause flags, start-up delays and special register reset values
// Assumes: Events arrive as single-cycle pulses on aclk; pins are asynchronous
// Notes: osc_in is sampled, not used as a clock
`include "rcc_defines.svh"
module rcc_top
	import rcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_pulse,
	input wire logic master_clear_n,
	input wire logic osc_in,
	input wire logic wdt_reset,
	input wire logic wdt_wake,
	input wire logic irq_wake,
	input wire logic [7:0] irq_wake_src,
	input wire logic sleeping,
	input wire logic [12:0] pc_in,
	input wire logic [7:0] sw_status_low,
	output logic core_reset,
	output logic [12:0] pc_out,
	output logic pc_load,
	output logic [7:0] status_out,
	output logic [7:0] option_out,
	output logic [7:0] port_a_direction_out,
	output logic [7:0] port_b_direction_out,
	output logic [7:0] irq_control_reg_out,
	output logic [4:0] pc_high_latch_out,
	output logic irq,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam logic [24:0] POWERUP_TIMER_CYC = 25'(`RCC_POWERUP_TIMER_CYC);
	localparam logic [10:0] OST_CYC = 11'(`RCC_OST_CYC);

	rcc_state_s s_reg;
	rcc_state_s s_next;
	logic master_clear_n_low;
	logic osc_rise;
	logic is_crystal;
	logic do_write;
	logic do_read;
	logic [9:0] wr_addr;
	logic [3:0] ev;
	logic [7:0] power_control_rd;
	logic [12:0] pc_next_r;
	logic pc_load_next;

	function automatic logic crystal(input logic [1:0] m);
		crystal = (m != RCC_MODE_RC);
	endfunction : crystal

	// ----------------------------------------
	// Start-up sequencing and reset causes
	// ----------------------------------------
	assign master_clear_n_low = ~s_reg.master_clear_n_sync[1];
	assign osc_rise = s_reg.osc_sync[1] & ~s_reg.osc_last;
	assign is_crystal = crystal(s_reg.osc_mode);
	assign do_write = (s_reg.aw_hold | s_axi_awvalid) & (s_reg.w_hold | s_axi_wvalid)
		& ~s_reg.bvalid;
	assign do_read = s_axi_arvalid & ~s_reg.rvalid;
	assign wr_addr = s_reg.aw_hold ? s_reg.aw_addr : s_axi_awaddr;
	assign power_control_rd = {6'h00, s_reg.core.por_flag, 1'b0};

	always_comb begin
		logic [31:0] wd;
		logic [7:0] rd;
		wd = s_reg.w_hold ? s_reg.w_data : s_axi_wdata;
		rd = `RCC_ZERO8;
		s_next = s_reg;
		ev = 4'h0;
		pc_next_r = s_reg.core.pc;
		pc_load_next = 1'b0;
		s_next.master_clear_n_sync = {s_reg.master_clear_n_sync[0], master_clear_n};
		s_next.osc_sync = {s_reg.osc_sync[0], osc_in};
		s_next.osc_last = s_reg.osc_sync[1];
		s_next.sleep_q = sleeping;
		if (por_pulse) begin
			s_next.state = RCC_IDLE;
			s_next.cnt = '0;
			s_next.ost_cnt = '0;
			s_next.pending_vec = 1'b0;
			s_next.core.pc = `RCC_RESET_VEC;
			s_next.core.option = `RCC_ALL_ONES;
			s_next.core.port_a_direction = `RCC_ALL_ONES;
			s_next.core.port_b_direction = `RCC_ALL_ONES;
			s_next.core.irq_control_reg = {7'h00, s_reg.core.irq_control_reg[0]};
			s_next.core.pc_high_latch = 5'h00;
			s_next.core.por_flag = 1'b0;
			s_next.core.status = {3'b000, 2'b11, s_reg.core.status[2:0]};
			ev[0] = 1'b1;
		end else begin
			case (s_reg.state)
				RCC_IDLE: begin
					// Power-up timer starts once the pulse is gone
					if (~s_reg.powerup_timer_enable_n_n) begin
						s_next.state = RCC_POWERUP_TIMER;
					end else if (is_crystal) begin
						s_next.state = RCC_OST;
					end else begin
						s_next.state = RCC_HOLD;
					end
				end
				RCC_POWERUP_TIMER: begin
					s_next.cnt = s_reg.cnt + 25'd1;
					if (s_reg.cnt == POWERUP_TIMER_CYC - 25'd1) begin
						s_next.state = is_crystal ? RCC_OST : RCC_HOLD;
					end
				end
				RCC_OST: begin
					if (osc_rise) begin
						s_next.ost_cnt = s_reg.ost_cnt + 11'd1;
						if (s_reg.ost_cnt == OST_CYC - 11'd1) begin
							s_next.state = RCC_HOLD;
						end
					end
				end
				RCC_HOLD: begin
					if (~master_clear_n_low) begin
						s_next.state = RCC_RUN;
						// PC already holds the reset or wake address
						pc_load_next = 1'b1;
					end
				end
				RCC_RUN: begin
					if (master_clear_n_low | wdt_reset) begin
						// Reset of special registers except por_flag and irq_control_reg bit 0
						s_next.core.pc = `RCC_RESET_VEC;
						s_next.core.option = `RCC_ALL_ONES;
						s_next.core.port_a_direction = `RCC_ALL_ONES;
						s_next.core.port_b_direction = `RCC_ALL_ONES;
						s_next.core.irq_control_reg = {7'h00, s_reg.core.irq_control_reg[0]};
						s_next.core.pc_high_latch = 5'h00;
						s_next.pending_vec = 1'b0;
						pc_next_r = `RCC_RESET_VEC;
						pc_load_next = 1'b1;
						if (wdt_reset & ~master_clear_n_low) begin
							s_next.core.status = {5'b00001, s_reg.core.status[2:0]};
							ev[1] = 1'b1;
						end else begin
							s_next.core.status = {4'b0001, ~s_reg.sleep_q,
								s_reg.core.status[2:0]};
							ev[2] = 1'b1;
							s_next.state = RCC_HOLD;
						end
					end else if (wdt_wake & s_reg.sleep_q) begin
						s_next.core.status = {s_reg.core.status[7:5], 2'b00,
							s_reg.core.status[2:0]};
						pc_next_r = pc_in + 13'd1;
						pc_load_next = 1'b1;
						s_next.cnt = '0;
						s_next.ost_cnt = '0;
						ev[3] = 1'b1;
						if (is_crystal) begin
							s_next.state = RCC_OST;
						end
					end else if (irq_wake & s_reg.sleep_q) begin
						s_next.core.status = {s_reg.core.status[7:5], 2'b10,
							s_reg.core.status[2:0]};
						s_next.core.irq_control_reg = s_reg.core.irq_control_reg | irq_wake_src;
						pc_next_r = pc_in + 13'd1;
						pc_load_next = 1'b1;
						s_next.pending_vec = s_reg.core.irq_control_reg[7];
						ev[3] = 1'b1;
						if (is_crystal) begin
							s_next.ost_cnt = '0;
							s_next.state = RCC_OST;
						end
					end else if (s_reg.pending_vec) begin
						pc_next_r = `RCC_IRQ_VEC;
						s_next.pending_vec = 1'b0;
						pc_load_next = 1'b1;
					end else begin
						s_next.core.status[2:0] = sw_status_low[2:0];
					end
				end
				default: s_next.state = RCC_IDLE;
			endcase
		end
		if (pc_load_next) begin
			s_next.core.pc = pc_next_r;
		end
		// ----------------------------------------
		// AXI4-Lite slave
		// ----------------------------------------
		if (s_axi_awvalid & ~s_reg.aw_hold & ~do_write) begin
			s_next.aw_hold = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid & ~s_reg.w_hold & ~do_write) begin
			s_next.w_hold = 1'b1;
			s_next.w_data = s_axi_wdata;
		end
		s_next.irq_stat = s_next.irq_stat | ev;
		if (do_write) begin
			s_next.aw_hold = 1'b0;
			s_next.w_hold = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = 2'b00;
			case (wr_addr)
				`RCC_OFF_POWER_CONTROL: s_next.core.por_flag = s_next.core.por_flag
					| (wd[`RCC_POWER_CONTROL_POR_BIT] & ~por_pulse);
				`RCC_OFF_IRQ_STAT: s_next.irq_stat = (s_reg.irq_stat & ~wd[3:0]) | ev;
				`RCC_OFF_IRQ_MASK: s_next.irq_mask = wd[3:0];
				`RCC_OFF_CTRL: begin
					s_next.osc_mode = wd[1:0];
					s_next.powerup_timer_enable_n_n = wd[2];
				end
				`RCC_OFF_STATUS: ;
				default: s_next.bresp = 2'b10;
			endcase
		end else if (s_reg.bvalid & s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (do_read) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = 2'b00;
			case (s_axi_araddr)
				`RCC_OFF_STATUS: rd = s_reg.core.status;
				`RCC_OFF_POWER_CONTROL: rd = power_control_rd;
				`RCC_OFF_IRQ_STAT: rd = {4'h0, s_reg.irq_stat};
				`RCC_OFF_IRQ_MASK: rd = {4'h0, s_reg.irq_mask};
				`RCC_OFF_CTRL: rd = {5'h00, s_reg.powerup_timer_enable_n_n, s_reg.osc_mode};
				`RCC_OFF_CORE: rd = {3'b000, s_reg.state, core_reset, 1'b0};
				default: s_next.rresp = 2'b10;
			endcase
			s_next.rdata = {24'h00_0000, rd};
		end else if (s_reg.rvalid & s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.state <= RCC_IDLE;
			s_reg.core.status <= `RCC_STATUS_RST;
			s_reg.core.option <= `RCC_ALL_ONES;
			s_reg.core.port_a_direction <= `RCC_ALL_ONES;
			s_reg.core.port_b_direction <= `RCC_ALL_ONES;
			// Idle level of the pin, no false master clear
			s_reg.master_clear_n_sync <= 2'b11;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_load <= 1'b0;
		end else begin
			pc_load <= pc_load_next;
		end
	end

	assign core_reset = (s_reg.state != RCC_RUN);
	assign pc_out = s_reg.core.pc;
	assign status_out = s_reg.core.status;
	assign option_out = s_reg.core.option;
	assign port_a_direction_out = s_reg.core.port_a_direction;
	assign port_b_direction_out = s_reg.core.port_b_direction;
	assign irq_control_reg_out = s_reg.core.irq_control_reg;
	assign pc_high_latch_out = s_reg.core.pc_high_latch;
	assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
	assign s_axi_awready = ~s_reg.aw_hold & ~s_reg.bvalid;
	assign s_axi_wready = ~s_reg.w_hold & ~s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = ~s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_por_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		por_pulse |=> !s_reg.core.por_flag)
		else $error("power-on flag not cleared");
	chk_por_sets_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		por_pulse |=> s_reg.core.status[4:3] == 2'b11)
		else $error("time-out/power-down not set on power-on");
	chk_wdt_reset_code: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.state == RCC_RUN && wdt_reset && !master_clear_n_low && !por_pulse)
		|=> s_reg.core.status[4:3] == 2'b01 && s_reg.core.pc == 13'h0000)
		else $error("watchdog reset code wrong");
	chk_wdt_wake_code: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.state == RCC_RUN && !wdt_reset && !master_clear_n_low && wdt_wake && s_reg.sleep_q
		&& !por_pulse) |=> s_reg.core.status[4:3] == 2'b00
		&& s_reg.core.pc == $past(pc_in) + 13'd1)
		else $error("watchdog wake code wrong");
	chk_reset_regs: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.state == RCC_RUN && master_clear_n_low && !por_pulse)
		|=> s_reg.core.option == 8'hFF && s_reg.core.port_b_direction == 8'hFF
		&& s_reg.core.pc_high_latch == 5'h00)
		else $error("reset register values wrong");
	chk_irq_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.pending_vec && s_reg.state == RCC_RUN && !master_clear_n_low && !wdt_reset
		&& !wdt_wake && !irq_wake && !por_pulse) |=> s_reg.core.pc == 13'h0004)
		else $error("interrupt vector not loaded");
	chk_power_control_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_read && s_axi_araddr == `RCC_OFF_POWER_CONTROL)
		|=> s_axi_rdata[31:2] == 30'h0000_0000 && s_axi_rdata[0] == 1'b0)
		else $error("unimplemented bits nonzero");
	chk_ost_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.state == RCC_OST && !por_pulse
		&& !(osc_rise && s_reg.ost_cnt == OST_CYC - 11'd1))
		|=> s_reg.state == RCC_OST && core_reset)
		else $error("reset released during start-up");
	chk_master_clear_n_release: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_reg.state == RCC_HOLD && !master_clear_n_low && !por_pulse) |=> !core_reset)
		else $error("late master clear release delayed");
endmodule : rcc_top

// ==== test/reset_cause_and_timeout_control_test.sv ====
// Purpose: Self-checking bench for the reset cause and start-up delay block
// Assumes: RC mode with the power-up timer off keeps start-up short
// Notes: Status is compared whole after reset and on the STATUS read, elsewhere only bits 7:3; low bits follow sw_status_low
`include "rcc_defines.svh"
module reset_cause_and_timeout_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, por_pulse = 0, master_clear_n = 1, osc_in = 0;
	logic wdt_reset = 0, wdt_wake = 0, irq_wake = 0, sleeping = 0;
	logic [7:0] irq_wake_src = 8'h00, sw_status_low = 8'h00;
	logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [12:0] pc_in = 13'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic core_reset, pc_load, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [12:0] pc_out;
	logic [7:0] status_out, option_out, port_a_direction_out, port_b_direction_out, irq_control_reg_out;
	logic [4:0] pc_high_latch_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	int err_total = 0;
	int tests_run = 0;

	always #2 aclk = ~aclk;

	rcc_top dut (.aclk, .aresetn, .por_pulse, .master_clear_n, .osc_in, .wdt_reset,
		.wdt_wake, .irq_wake, .irq_wake_src, .sleeping, .pc_in, .sw_status_low,
		.core_reset, .pc_out, .pc_load, .status_out, .option_out, .port_a_direction_out,
		.port_b_direction_out, .irq_control_reg_out, .pc_high_latch_out, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : ck

	task automatic hang;
		err_total++;
		$display("[FAIL] t=%0t wait ran out", $time);
		end_of_test();
	endtask : hang

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
		if (n >= 50) hang();
	endtask : wr

	task automatic rd_reg(input logic [9:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
		if (n >= 50) hang();
	endtask : rd_reg

	task automatic wait_run;
		int n;
		n = 0;
		while (core_reset !== 1'b0 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 100) hang();
		repeat (2) @(posedge aclk);
	endtask : wait_run

	// One-cycle event: 0 power-on, 1 watchdog reset, 2 watchdog wake, 3 irq wake
	task automatic evt(input int k);
		@(posedge aclk);
		por_pulse <= (k == 0);
		wdt_reset <= (k == 1);
		wdt_wake <= (k == 2);
		irq_wake <= (k == 3);
		@(posedge aclk);
		{por_pulse, wdt_reset, wdt_wake, irq_wake} <= 4'h0;
		repeat (4) @(posedge aclk);
	endtask : evt

	task automatic osc(input int k);
		repeat (k) begin
			@(posedge aclk);
			osc_in <= 1;
			repeat (2) @(posedge aclk);
			osc_in <= 0;
			@(posedge aclk);
		end
	endtask : osc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_por;
		ck(status_out, 8'h18);
		ck({option_out, port_a_direction_out, port_b_direction_out}, 24'hff_ffff);
		rd_reg(`RCC_OFF_CORE);
		ck(rd, 32'h0000_0006);
		wr(`RCC_OFF_CTRL, 32'h0000_0007);
		rd_reg(`RCC_OFF_CTRL);
		ck(rd, 32'h0000_0007);
		evt(0);
		wait_run();
		rd_reg(`RCC_OFF_POWER_CONTROL);
		ck(rd, 32'h0000_0000);
		ck(status_out & 8'hf8, 8'h18);
		ck(pc_out, 13'h0000);
		ck({option_out, port_a_direction_out, port_b_direction_out}, 24'hff_ffff);
		ck({irq_control_reg_out[7:1], pc_high_latch_out}, 12'h000);
		$display("power-on test done");
	endtask : t_por

	task automatic t_irq;
		rd_reg(`RCC_OFF_IRQ_STAT);
		ck(rd, 32'h0000_0001);
		wr(`RCC_OFF_IRQ_MASK, 32'h0000_0001);
		ck(irq, 1'b1);
		wr(`RCC_OFF_IRQ_MASK, 32'h0000_0000);
		ck(irq, 1'b0);
		wr(`RCC_OFF_IRQ_MASK, 32'h0000_0001);
		wr(`RCC_OFF_IRQ_STAT, 32'h0000_0001);
		ck(irq, 1'b0);
		rd_reg(10'h020);
		ck(resp, 2'b10);
		wr(10'h020, 32'h0000_0001);
		ck(resp, 2'b10);
		$display("interrupt test done");
	endtask : t_irq

	task automatic t_wdt;
		wr(`RCC_OFF_POWER_CONTROL, 32'h0000_00ff);
		rd_reg(`RCC_OFF_POWER_CONTROL);
		ck(rd, 32'h0000_0002);
		evt(1);
		wait_run();
		ck(status_out & 8'hf8, 8'h08);
		ck(pc_out, 13'h0000);
		rd_reg(`RCC_OFF_STATUS);
		ck(rd, 32'h0000_0008);
		rd_reg(`RCC_OFF_POWER_CONTROL);
		ck(rd, 32'h0000_0002);
		$display("watchdog reset test done");
	endtask : t_wdt

	task automatic t_wake;
		int n;
		sleeping <= 1;
		pc_in <= 13'h0123;
		evt(2);
		ck(status_out & 8'hf8, 8'h00);
		ck(pc_out, 13'h0124);
		ck({option_out, port_b_direction_out}, 16'hffff);
		irq_wake_src <= 8'h02;
		evt(3);
		ck(status_out & 8'hf8, 8'h10);
		ck(pc_out, 13'h0124);
		ck(irq_control_reg_out[1], 1'b1);
		irq_wake_src <= 8'h80;
		evt(3);
		irq_wake_src <= 8'h00;
		evt(3);
		n = 0;
		while (pc_out !== `RCC_IRQ_VEC && n < 20) begin
			@(posedge aclk);
			n++;
		end
		ck(pc_out, `RCC_IRQ_VEC);
		ck(option_out, 8'hff);
		sleeping <= 0;
		rd_reg(`RCC_OFF_IRQ_STAT);
		ck(rd, 32'h0000_000a);
		$display("wake test done");
	endtask : t_wake

	task automatic t_master_clear_n(input logic slp, input logic [7:0] exp);
		sleeping <= slp;
		@(posedge aclk);
		master_clear_n <= 0;
		repeat (20) @(posedge aclk);
		master_clear_n <= 1;
		sleeping <= 0;
		repeat (4) @(posedge aclk);
		ck(pc_load, 1'b1);
		@(posedge aclk);
		ck(core_reset, 1'b0);
		ck(pc_load, 1'b0);
		repeat (2) @(posedge aclk);
		ck(status_out & 8'hf8, exp);
		ck({pc_out, irq_control_reg_out[7:1]}, 20'h0_0000);
		$display("master clear test done");
	endtask : t_master_clear_n

	task automatic t_ost;
		wr(`RCC_OFF_CTRL, 32'h0000_0006);
		evt(0);
		osc(1023);
		ck(core_reset, 1'b1);
		osc(20);
		ck(core_reset, 1'b0);
		wr(`RCC_OFF_CTRL, 32'h0000_0005);
		sleeping <= 1;
		evt(2);
		ck(core_reset, 1'b1);
		osc(1040);
		sleeping <= 0;
		ck(core_reset, 1'b0);
		ck(pc_out, 13'h0124);
		$display("start-up timer test done");
	endtask : t_ost

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_por();
		t_irq();
		t_wdt();
		t_wake();
		t_master_clear_n(1'b0, 8'h18);
		t_master_clear_n(1'b1, 8'h10);
		t_ost();
		end_of_test();
	end
endmodule : reset_cause_and_timeout_control_test
